// ---- include/acc_pkg.sv ----
// package: constants and types of the conversion control block
package acc_pkg;

    // ------------------------------------------------------------
    // widths and frame layout
    // ------------------------------------------------------------
    localparam int          RES_W      = 32;        // bits per frame
    localparam int          CFG_W      = 16;        // config bits kept
    localparam logic [5:0]  FRAME_BITS = 6'h20;     // 32 bits per frame
    localparam int          SPEED_BIT  = 0;         // 2x speed select
    localparam logic [15:0] CFG_RESET  = 16'h0000;  // ch0/ch1, 50/60, 1x
    localparam logic [31:0] OVR_CODE   = 32'h3000_0000; // over range
    localparam logic [31:0] UNDR_CODE  = 32'h1fff_ffff; // under range

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ      = 20_000_000;   // system clock
    localparam int SYS_PERIOD_NS   = 50;           // system period
    localparam int OSC_FREQ_HZ     = 307_200;      // internal oscillator
    localparam int OSC_DIV         = SYS_CLK_HZ / OSC_FREQ_HZ;
    localparam int ISCK_HALF_TICKS = 4;            // sck = osc / 8
    localparam int CONV_TICKS_1X   = 41036;        // osc ticks, 1x
    localparam int CONV_TICKS_2X   = 20556;        // osc ticks, 2x
    localparam int EXT_TMO_NS      = 200_000;      // no f0 edge: internal
    localparam int EXT_TMO_CYC     = EXT_TMO_NS / SYS_PERIOD_NS;
    localparam logic [1:0] INIT_LATCH = 2'h2;      // power-up sample

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CONV  = 2'h0,    // converting
        ST_SLEEP = 2'h1,    // result held
        ST_XFER  = 2'h3     // data in/out
    } acc_state_type;

    typedef struct packed {
        logic             speed_2x;  // decoded speed select
        logic [CFG_W-1:0] word;      // raw config for the front end
    } acc_cfg_type;

    typedef struct packed {
        logic             ovr;       // input above +fs
        logic             undr;      // input below -fs
        logic [RES_W-1:0] word;      // normal result
    } acc_res_type;

endpackage : acc_pkg

// ---- hw/acc_link_shift.sv ----
// link-clock shift engine for external serial clock frames
`timescale 1ns/1ns
module acc_link_shift (
    input  wire logic                      sck_clk_i, // link clock
    input  wire logic                      rst_i,     // async reset
    input  wire logic                      cs_n_i,    // raw select, clears
    input  wire logic                      sdi_i,     // serial in
    input  wire logic [acc_pkg::RES_W-1:0] word_i,    // held result
    output logic                           sdo_o,     // serial out bit
    output logic                           started_o, // a rise seen
    output logic                           done_o,    // 32 rises seen
    output logic [acc_pkg::CFG_W-1:0]      cfg_o      // captured config
);
    import acc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0]       rise_q;   // rises in this frame
    logic [4:0]       idx_q;    // bit shown on sdo
    logic [CFG_W-1:0] cfg_q;    // config shift
    logic             frame_clr; // frame reset
    wire  [4:0]       last_idx = 5'(RES_W - 1);

    assign frame_clr = rst_i | cs_n_i;

    // rise side: count and capture sdi
    always_ff @(posedge sck_clk_i or posedge frame_clr) begin
        if (frame_clr) begin
            rise_q    <= 6'h00;
            started_o <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            started_o <= 1'b1;
            if (rise_q != FRAME_BITS) begin
                rise_q <= rise_q + 6'h01;
            end
            done_o <= (rise_q >= FRAME_BITS - 6'h01);
        end
    end

    // config shift survives the frame end for the other domain
    always_ff @(posedge sck_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= CFG_RESET;
        end else if (!cs_n_i && rise_q < 6'(CFG_W)) begin
            cfg_q <= {cfg_q[CFG_W-2:0], sdi_i};
        end
    end

    // fall side: advance the shown bit
    always_ff @(negedge sck_clk_i or posedge frame_clr) begin
        if (frame_clr) begin
            idx_q <= 5'h00;
        end else if (rise_q < FRAME_BITS) begin
            idx_q <= rise_q[4:0];
        end
    end

    assign sdo_o = word_i[last_idx - idx_q];
    assign cfg_o = cfg_q;

endmodule : acc_link_shift

// ---- hw/acc_conv_ctrl.sv ----
// conversion sequencing and serial interface control
`timescale 1ns/1ns
// Function
// - chip select low wakes device, enables io
// - sleep after conversion while select high
// - select rising in output aborts, converts
// - serial out floats while select high
// - result bits shifted out in data phase
// - status on serial out: high busy
// - sck level picks clock mode
// - internal mode drives sck itself
// - static control pin: internal oscillator
// - clock on control pin replaces oscillator
// - config bits shifted in with sck
// - first conversion after change is valid
// - channels single ended or differential
// - distinct over and under range codes
// - out changes on fall, in on rise
// - 32 bits or select high ends cycle
// - select high before rise: back to sleep
// - reset config: ch0/ch1, 50/60, 1x
module acc_conv_ctrl #(
    parameter int CONV_1X = acc_pkg::CONV_TICKS_1X, // 1x length
    parameter int CONV_2X = acc_pkg::CONV_TICKS_2X  // 2x length
) (
    input  wire logic                 sys_clk_i,  // system clock
    input  wire logic                 rst_i,      // async reset
    input  wire logic                 sck_clk_i,  // sck, external mode
    input  wire logic                 cs_n_i,     // chip select pin
    input  wire logic                 sck_i,      // sck pin level
    output logic                      sck_o,      // sck drive value
    output logic                      sck_oe_o,   // sck drive enable
    input  wire logic                 sdi_i,      // serial in pin
    output logic                      sdo_o,      // serial out value
    output logic                      sdo_oe_o,   // serial out enable
    input  wire logic                 f0_i,       // clock control pin
    input  wire acc_pkg::acc_res_type res_i,      // filter result
    output acc_pkg::acc_cfg_type      cfg_o,      // active config
    output logic                      start_o,    // conversion start
    output logic                      busy_o,     // converting
    output logic                      sleep_o,    // low power
    output logic                      ext_osc_o,  // external clock used
    output logic                      int_mode_o  // internal sck mode
);
    import acc_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [5:0] s1_q;   // first stage
    logic [5:0] s2_q;   // second stage
    logic       link_started; // from link domain
    logic       link_done;    // from link domain

    // pins and the link started/done flags cross by two flops
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 6'h21;
            s2_q <= 6'h21;
        end else begin
            s1_q <= {cs_n_i, sck_i, sdi_i, f0_i, link_started, link_done};
            s2_q <= s1_q;
        end
    end

    wire cs_n_s  = s2_q[5]; // select
    wire sck_s   = s2_q[4]; // sck level
    wire sdi_s   = s2_q[3]; // serial in
    wire f0_s    = s2_q[2]; // control pin
    wire start_s = s2_q[1]; // link started
    wire done_s  = s2_q[0]; // link done

    // ------------------------------------------------------------
    // edge history
    // ------------------------------------------------------------
    logic cs_prev_q; // select last cycle
    logic f0_prev_q; // control pin last cycle
    logic [1:0] init_q; // power-up sampling

    // edges read the second stage only
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_prev_q <= 1'b1;
            f0_prev_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_n_s;
            f0_prev_q <= f0_s;
        end
    end

    wire cs_fall = cs_prev_q & ~cs_n_s;
    wire cs_rise = ~cs_prev_q & cs_n_s;
    // a pin tied high would look like a rise while the history fills
    wire f0_edge = ~f0_prev_q & f0_s & (init_q == 2'h3);

    // ------------------------------------------------------------
    // conversion clock source
    // ------------------------------------------------------------
    logic [6:0]  osc_q;  // oscillator divider
    logic [12:0] tmo_q;  // cycles left before fallback to internal
    logic        ext_q;  // external clock present

    wire osc_tick = (osc_q == 7'(OSC_DIV - 1));

    // internal oscillator model
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_q <= 7'h00;
        end else if (osc_tick) begin
            osc_q <= 7'h00;
        end else begin
            osc_q <= osc_q + 7'h01;
        end
    end

    // a static pin never edges, so the timeout falls back
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_q <= 13'h0000;
            ext_q <= 1'b0;
        end else if (f0_edge) begin
            tmo_q <= 13'(EXT_TMO_CYC);
            ext_q <= 1'b1;
        end else if (tmo_q == 13'h0000) begin
            ext_q <= 1'b0;
        end else begin
            tmo_q <= tmo_q - 13'h0001;
        end
    end

    wire conv_tick = ext_q ? f0_edge : osc_tick;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    acc_state_type    state_q;   // operating state
    logic [15:0]      conv_q;    // conversion ticks
    logic [RES_W-1:0] res_q;     // held result
    acc_cfg_type      cfg_q;     // config in use
    logic [CFG_W-1:0] stage_q;   // config for next conversion
    logic             start_q;   // start pulse
    logic             mode_q;    // 1: internal sck
    logic             xstart_q;  // sticky link started
    logic [CFG_W-1:0] link_cfg;  // link config word
    logic             link_sdo;  // link serial bit

    wire [15:0] conv_len  = cfg_q.speed_2x ? 16'(CONV_2X - 1) : 16'(CONV_1X - 1);
    wire        conv_end  = (state_q == ST_CONV) && conv_tick && (conv_q == conv_len);
    wire        in_xfer   = (state_q == ST_XFER);

    // internal sck frame signals, declared ahead of use
    logic [5:0]       icnt_q;  // internal rises
    logic [CFG_W-1:0] icfg_q;  // internal config shift
    wire        int_act  = in_xfer && mode_q && !cs_n_s;
    wire        started  = mode_q ? (icnt_q != 6'h00) : xstart_q;
    wire        bits_end = mode_q ? (icnt_q == FRAME_BITS) : done_s;
    wire        xfer_end = in_xfer && (bits_end || (cs_rise && started));
    wire        xfer_nop = in_xfer && cs_rise && !started;
    wire [CFG_W-1:0] new_cfg = mode_q ? icfg_q : link_cfg;

    // out-of-range inputs replace the word with fixed codes
    wire [RES_W-1:0] res_word = res_i.ovr  ? OVR_CODE :
                                res_i.undr ? UNDR_CODE : res_i.word;

    // state transitions
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_CONV;
        end else begin
            case (state_q)
                ST_CONV: begin
                    if (conv_end) state_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (!cs_n_s) state_q <= ST_XFER;
                end
                ST_XFER: begin
                    if (xfer_end) begin
                        state_q <= ST_CONV;
                    end else if (xfer_nop) begin
                        state_q <= ST_SLEEP;
                    end
                end
                default: state_q <= ST_CONV;
            endcase
        end
    end

    // conversion count, result and config hand-off
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_q  <= 16'h0000;
            res_q   <= '0;
            cfg_q   <= '0;
            stage_q <= CFG_RESET;
            start_q <= 1'b1;
        end else begin
            start_q <= xfer_end;
            if (xfer_end) begin
                // every new conversion is valid, none discarded
                cfg_q.word     <= new_cfg;
                cfg_q.speed_2x <= new_cfg[SPEED_BIT];
                stage_q        <= new_cfg;
                conv_q         <= 16'h0000;
            end else if (state_q == ST_CONV && conv_tick) begin
                conv_q <= conv_q + 16'h0001;
            end
            if (conv_end) res_q <= res_word;
        end
    end

    // clock mode caught after reset release and at each select fall
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_q <= 2'h0;
            mode_q <= 1'b0;
        end else begin
            if (init_q != 2'h3) init_q <= init_q + 2'h1;
            if (init_q == INIT_LATCH || cs_fall) begin
                mode_q <= sck_s;
            end
        end
    end

    // link start seen during this frame; survives the async clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xstart_q <= 1'b0;
        end else if (!in_xfer) begin
            xstart_q <= 1'b0;
        end else if (start_s) begin
            xstart_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // internal serial clock
    // ------------------------------------------------------------
    logic [1:0] half_q; // ticks in this half period
    logic       isck_q; // generated sck, idles high
    logic       ibit_q; // bit shown on sdo

    wire half_end = int_act && conv_tick && (half_q == 2'(ISCK_HALF_TICKS - 1));
    wire [4:0] ibit_idx = 5'(RES_W - 1) - icnt_q[4:0];

    // clock runs only after the conversion and with select low
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_q <= 2'h0;
            isck_q <= 1'b1;
            icnt_q <= 6'h00;
            ibit_q <= 1'b0;
            icfg_q <= CFG_RESET;
        end else if (!int_act) begin
            half_q <= 2'h0;
            isck_q <= 1'b1;
            icnt_q <= 6'h00;
            ibit_q <= res_q[RES_W-1];
            icfg_q <= stage_q;
        end else begin
            if (conv_tick) half_q <= half_q + 2'h1;
            if (half_end && icnt_q != FRAME_BITS) begin
                isck_q <= ~isck_q;
                if (isck_q) begin
                    ibit_q <= res_q[ibit_idx];
                end else begin
                    icnt_q <= icnt_q + 6'h01;
                    if (icnt_q < 6'(CFG_W)) begin
                        icfg_q <= {icfg_q[CFG_W-2:0], sdi_s};
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // link-clock engine, external sck
    // ------------------------------------------------------------
    // result is static while the link shifts, so it is read directly
    acc_link_shift u_link (
        .sck_clk_i (sck_clk_i),
        .rst_i     (rst_i),
        .cs_n_i    (cs_n_i),
        .sdi_i     (sdi_i),
        .word_i    (res_q),
        .sdo_o     (link_sdo),
        .started_o (link_started),
        .done_o    (link_done),
        .cfg_o     (link_cfg)
    );

    // ------------------------------------------------------------
    // pins and status
    // ------------------------------------------------------------
    // data in transfer, busy flag otherwise
    assign sdo_o      = in_xfer ? (mode_q ? ibit_q : link_sdo)
                                : (state_q == ST_CONV);
    assign sdo_oe_o   = !cs_n_s;
    assign sck_o      = isck_q;
    assign sck_oe_o   = int_act;
    assign cfg_o      = cfg_q;
    assign start_o    = start_q;
    assign busy_o     = (state_q == ST_CONV);
    assign sleep_o    = (state_q == ST_SLEEP) && cs_n_s;
    assign ext_osc_o  = ext_q;
    assign int_mode_o = mode_q;

endmodule : acc_conv_ctrl

// ---- verification/acc_conv_ctrl_props.sv ----
// checker: port relations of the conversion control block
`timescale 1ns/1ns
module acc_conv_ctrl_props #(
    parameter int CONV_1X = 40, // 1x length
    parameter int CONV_2X = 20  // 2x length
) (
    input wire logic                 sys_clk_i,  // system clock
    input wire logic                 rst_i,      // async reset
    input wire logic                 cs_n_i,     // chip select
    input wire logic                 f0_i,       // clock control pin
    input wire logic                 sdo_o,      // serial out value
    input wire logic                 sdo_oe_o,   // serial out enable
    input wire logic                 sck_oe_o,   // sck drive enable
    input wire acc_pkg::acc_cfg_type cfg_o,      // active config
    input wire logic                 start_o,    // conversion start
    input wire logic                 busy_o,     // converting
    input wire logic                 sleep_o,    // low power
    input wire logic                 ext_osc_o,  // external clock used
    input wire logic                 int_mode_o  // internal sck mode
);
    import acc_pkg::*;

    // ----
    // helper: quiet time of the clock control pin
    // ----
    logic [12:0] still_q; // saturating, well past the detect window

    // restart on any movement of f0
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            still_q <= 13'h0000;
        end else if ($changed(f0_i)) begin
            still_q <= 13'h0000;
        end else if (still_q != 13'h1fff) begin
            still_q <= still_q + 13'h0001;
        end
    end

    // ----
    // properties; 4 samples cover the select synchroniser
    // ----
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_IO_ENABLE: assert property (!cs_n_i [*4] |-> sdo_oe_o)
        else $error("serial out not enabled under select");
    AST_SDO_FLOAT: assert property (cs_n_i [*4] |-> !sdo_oe_o)
        else $error("serial out driven while deselected");
    AST_STATUS_BUSY: assert property (sdo_oe_o && busy_o |-> sdo_o)
        else $error("status not high during conversion");
    AST_SLEEP_SAFE: assert property (sleep_o |-> !busy_o && !sck_oe_o)
        else $error("sleep while converting or clocking");
    AST_SLEEP_HOLD: assert property (cs_n_i [*4] ##0 sleep_o |=> sleep_o)
        else $error("left sleep with select high");
    AST_START_BUSY: assert property (start_o |=> busy_o [*8])
        else $error("conversion did not run after start");
    AST_SCK_OWNER: assert property (sck_oe_o |-> int_mode_o && !busy_o && sdo_oe_o)
        else $error("sck driven at the wrong time");
    AST_EXT_INPUT: assert property (!int_mode_o |-> !sck_oe_o)
        else $error("sck driven in external mode");
    AST_CFG_CHANGE: assert property ($changed(cfg_o) |-> start_o)
        else $error("config changed outside a start");
    AST_OSC_INTERNAL: assert property (still_q == 13'h1fff |-> !ext_osc_o)
        else $error("external clock flagged on a static pin");

    COV_START: cover property (start_o);
    COV_INT_SCK: cover property (sck_oe_o);
    COV_SLEEP: cover property (sleep_o);
endmodule : acc_conv_ctrl_props

bind acc_conv_ctrl acc_conv_ctrl_props #(
    .CONV_1X(CONV_1X),
    .CONV_2X(CONV_2X)
) u_acc_conv_ctrl_props (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .cs_n_i    (cs_n_i),
    .f0_i      (f0_i),
    .sdo_o     (sdo_o),
    .sdo_oe_o  (sdo_oe_o),
    .sck_oe_o  (sck_oe_o),
    .cfg_o     (cfg_o),
    .start_o   (start_o),
    .busy_o    (busy_o),
    .sleep_o   (sleep_o),
    .ext_osc_o (ext_osc_o),
    .int_mode_o(int_mode_o)
);

// ---- verification/acc_host_model.sv ----
// host controller model on the serial side of the converter
`timescale 1ns/1ns
module acc_host_model (
    input  wire logic  sys_clk_i,  // system clock
    input  wire logic  sck_i,      // resolved sck pin
    input  wire logic  sdo_i,      // resolved serial out pin
    output logic       cs_n_o,     // chip select, active low
    output logic       sck_o,      // host sck drive
    output logic       sdi_o,      // serial in
    output logic [31:0] rx_o,      // word of the last full frame
    output logic       rx_valid_o  // one cycle: word ready
);
    // idle: deselected, sck still low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
        rx_o = 32'h0000_0000;
        rx_valid_o = 1'b0;
    end

    // poll sck (sel) or sdo for a level; bounded so a dead pin ends
    task automatic wait_pin(input logic sel, input logic lvl, inout logic ok);
        int n;
        n = 0;
        while (((sel ? sck_i : sdo_i) !== lvl) && n < 6000) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n == 6000) ok = 1'b0;
    endtask : wait_pin

    // one frame: nbits sck rises, config msb first, result read on rises
    task automatic frame(input logic ext, input logic [15:0] cfg, input int nbits,
                         input logic poll, output logic ok);
        logic [31:0] rx;
        ok = 1'b1;
        rx = 32'h0000_0000;
        sck_o <= ~ext;                           // level picks sck mode
        repeat (4) @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        if (poll) wait_pin(1'b0, 1'b0, ok);     // status low: done
        repeat (6) @(posedge sys_clk_i);
        #7;
        for (int i = 0; i < nbits; i++) begin
            if (ext) begin
                sdi_o = (i < 16) ? cfg[15 - i] : 1'b0;
                #32 sck_o = 1'b1;                // clock only inside frames
                rx = {rx[30:0], sdo_i};          // taken on the rise
                #32 sck_o = 1'b0;
            end else begin
                wait_pin(1'b1, 1'b0, ok);
                sdi_o <= (i < 16) ? cfg[15 - i] : 1'b0;
                wait_pin(1'b1, 1'b1, ok);
                rx = {rx[30:0], sdo_i};
            end
        end
        repeat (6) @(posedge sys_clk_i);        // gap before select rises
        cs_n_o <= 1'b1;                          // ends or aborts the frame
        if (nbits == 32) begin
            rx_o <= rx;
            rx_valid_o <= 1'b1;
            @(posedge sys_clk_i);
            rx_valid_o <= 1'b0;
        end
    endtask : frame
endmodule : acc_host_model

// ---- verification/acc_conv_ctrl_test.sv ----
// self-checking bench of the conversion control block
`timescale 1ns/1ns
module acc_conv_ctrl_test;
    import acc_pkg::*;

    logic        sys_clk_i, rst_i, f0_i, float_q;  // clock, reset, static f0
    acc_res_type res_i;                             // filter result
    acc_cfg_type cfg_o;                             // active config
    logic        sck_o, sck_oe_o, sdo_o, sdo_oe_o;  // pin drives
    logic        start_o, busy_o, sleep_o, ext_osc_o, int_mode_o; // status
    logic        cs_n, host_sck, serial_in_pin, rx_valid, ok; // host side
    logic [31:0] rx;                                // word read by host
    logic [15:0] cfg;                               // config sent
    logic [31:0] exp_q[$];                          // expected words
    int          failures, n_compared, n_start, s0;
    wire         sck_pin = sck_oe_o ? sck_o : host_sck;  // shared sck pin
    wire         sdo_pin = sdo_oe_o ? sdo_o : float_q;   // floats: toggles

    acc_conv_ctrl #(.CONV_1X(40), .CONV_2X(20)) u_acc_conv_ctrl (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sck_clk_i(sck_pin), .cs_n_i(cs_n),
        .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(serial_in_pin),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .f0_i(f0_i), .res_i(res_i),
        .cfg_o(cfg_o), .start_o(start_o), .busy_o(busy_o), .sleep_o(sleep_o),
        .ext_osc_o(ext_osc_o), .int_mode_o(int_mode_o));

    acc_host_model u_acc_host_model (
        .sys_clk_i(sys_clk_i), .sck_i(sck_pin), .sdo_i(sdo_pin), .cs_n_o(cs_n),
        .sck_o(host_sck), .sdi_o(serial_in_pin), .rx_o(rx), .rx_valid_o(rx_valid));

    // 20 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // ----
    // monitor: count starts, compare each word read
    // ----
    always @(posedge sys_clk_i) begin
        float_q <= ~float_q;
        if (start_o === 1'b1) n_start++;
        if (rx_valid === 1'b1) check(rx, exp_q.pop_front());
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic timeout();
        failures++;
        give_verdict();
    endtask : timeout

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    // result for the running conversion; range flags force fixed codes
    task automatic set_res(input int kind);
        logic [31:0] w;
        w = $urandom();
        @(posedge sys_clk_i);
        res_i <= '{ovr: kind == 1, undr: kind == 2, word: w};
        exp_q.push_back(kind == 1 ? OVR_CODE : (kind == 2 ? UNDR_CODE : w));
    endtask : set_res

    task automatic wait_start();
        int n;
        n = 0;
        while (n_start == s0 && n < 60) begin
            tick(1);
            n++;
        end
        if (n == 60) timeout();
    endtask : wait_start

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        timeout();
    end

    // ----
    // main sequence
    // ----
    initial begin
        int n;
        void'($urandom(38281));
        {failures, n_compared, n_start, float_q} = '0;
        rst_i <= 1'b1;
        f0_i <= 1'b0;
        res_i <= '0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(4);
        check(cfg_o, {1'b0, CFG_RESET});
        check(int_mode_o, 1'b0);
        check(sdo_oe_o, 1'b0);
        // full frames, modes alternating, normal/over/under results
        for (int k = 0; k < 4; k++) begin
            cfg = $urandom();
            set_res(k % 3);
            s0 = n_start;
            fork
                u_acc_host_model.frame(k[0] == 1'b0, cfg, 32, 1'b1, ok);
                begin
                    tick(12);
                    check(sdo_o, 1'b1);
                    check(sck_oe_o, 1'b0);
                    check(int_mode_o, k[0]);
                end
            join
            if (!ok) timeout();
            wait_start();
            tick(10);
            check(n_start, s0 + 1);
            check(cfg_o.word, cfg);
            check(cfg_o.speed_2x, cfg[SPEED_BIT]);
        end
        // abort after 8 bits
        s0 = n_start;
        u_acc_host_model.frame(1'b1, 16'h0000, 8, 1'b1, ok);
        if (!ok) timeout();
        wait_start();
        check(busy_o, 1'b1);
        set_res(0);
        n = 0;
        while (busy_o !== 1'b0 && n < 6000) begin
            tick(1);
            n++;
        end
        if (n == 6000) timeout();
        tick(4);
        check(sleep_o, 1'b1);
        // select blip with no sck rise
        s0 = n_start;
        u_acc_host_model.frame(1'b1, 16'h0000, 0, 1'b0, ok);
        tick(20);
        check(n_start, s0);
        check(sleep_o, 1'b1);
        u_acc_host_model.frame(1'b1, 16'h0000, 32, 1'b0, ok);
        if (!ok) timeout();
        tick(20);
        check(ext_osc_o, 1'b0);
        // clock on f0: 40 f0 rises end the conversion long before the oscillator
        repeat (240) @(posedge sys_clk_i) f0_i <= ~f0_i;
        tick(1);
        check(ext_osc_o, 1'b1);
        check(busy_o, 1'b0);
        give_verdict();
    end
endmodule : acc_conv_ctrl_test
